// [design/timer34_map.svh]
// How it works
// - bank index 011 reaches timer three, 100 reaches timer four.
// - overflow sets control bit 7; only a software zero clears it.
// - trigger falling edge sets bit 6 only while trigger enable is set.
// - trigger enable bit 3 gates trigger edges into capture or reload.
// - run bit 2 low stops counting, but an enabled trigger edge in reload mode still loads the count.
// - bit 1 picks internal clock timer or external pulse counter.
// - counter mode adds exactly one per falling edge on count pin.
// - bit 0 low selects reload, high selects capture from trigger pin.
// - mode bit 7 picks system clock over twelve or full clock.
// - mode bit 1 high drives the count pin; it is a clock output only while control bit 1 is low.
// - mode bit 0 allows up/down counting, direction from trigger pin.
// - timer three request passes only when enable bit 6 is set.
// - priority bit 6 marks timer three request high or low.
// - only capture, auto-reload and clock output modes exist.
// - capture copies current count into the capture register.
// - up reload overflows past ffff and loads the reload value.
// - down count overflows at reload value and loads ffff.
// - in up/down reload the event flag toggles, no interrupt.
`ifndef TIMER34_MAP_SVH
`define TIMER34_MAP_SVH
`define IE2_ADDR 8'ha9
`define IP2_ADDR 8'hb9
`define CTRL_ADDR 8'hc8
`define MODE_ADDR 8'hc9
`define RCAP_LO_ADDR 8'hca
`define RCAP_HI_ADDR 8'hcb
`define CNT_LO_ADDR 8'hcc
`define CNT_HI_ADDR 8'hcd
`define BANK_ADDR 8'hce
`define BANK_T3 3'h3
`define BANK_T4 3'h4
`define CTRL_TF 7
`define CTRL_EXF 6
`define CTRL_EXEN 3
`define CTRL_RUN 2
`define CTRL_CT 1
`define CTRL_CPRL 0
`define MODE_FD 7
`define MODE_OE 1
`define MODE_DCEN 0
`define IRQ_T3_BIT 6
`define IRQ_T4_BIT 7
`define IE2_RW_MASK 8'hcf
`define DIV_LAST 4'hb
`define CNT_TOP 16'hffff
`endif

// [design/timer34_pkg.sv]
package timer34_pkg;
    // mode 2 (baud generator) does not exist on these timers
    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_RELOAD = 2'b01,
        MODE_CLKOUT = 2'b11
    } op_mode_t;
endpackage

// [design/timer_unit.sv]
`timescale 1ns/1ns
`include "timer34_map.svh"
module timer_unit
    import timer34_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic div12_tick,
    input wire logic wr_ctrl,
    input wire logic wr_mode,
    input wire logic wr_cnt_lo,
    input wire logic wr_cnt_hi,
    input wire logic wr_rcap_lo,
    input wire logic wr_rcap_hi,
    input wire logic [7:0] wdata,
    input wire logic count_pin_i,
    input wire logic trig_pin_i,
    output logic [7:0] ctrl,
    output logic [7:0] mode,
    output logic [15:0] count,
    output logic [15:0] rcap,
    output logic tick,
    output logic irq_req,
    output logic count_pin_o,
    output logic count_pin_oe
);
    logic [3:0] ctl_q, ctl_d;
    logic tf_q, tf_d, exf_q, exf_d;
    logic fd_q, fd_d, oe_q, oe_d, dcen_q, dcen_d;
    logic [15:0] cnt_q, cnt_d, rcap_q, rcap_d;
    logic cpin_q, tpin_q, co_q, co_d;
    logic trig_fall, updown, up, ovf, ext_ev, base_exf;
    op_mode_t op;

    // ----------------------------------------
    // count engine
    // ----------------------------------------
    always_comb begin
        if (oe_q && !ctl_q[`CTRL_CT])
            op = MODE_CLKOUT;
        else if (ctl_q[`CTRL_CPRL])
            op = MODE_CAPTURE;
        else
            op = MODE_RELOAD;
        trig_fall = tpin_q & ~trig_pin_i;
        tick = ctl_q[`CTRL_RUN] & (ctl_q[`CTRL_CT] ?
            (cpin_q & ~count_pin_i) : (fd_q | div12_tick));
        updown = dcen_q & (op == MODE_RELOAD);
        up = ~updown | trig_pin_i;
        ovf = tick & (up ? (cnt_q == `CNT_TOP) : (cnt_q == rcap_q));
        // edges count only while enabled; ignored in up/down reload
        ext_ev = ctl_q[`CTRL_EXEN] & trig_fall & ~updown;
        cnt_d = cnt_q;
        if (tick) begin
            if (ovf && !up)
                cnt_d = `CNT_TOP;
            else if (ovf && op != MODE_CAPTURE)
                cnt_d = rcap_q;
            else if (up)
                cnt_d = cnt_q + 16'h0001;
            else
                cnt_d = cnt_q - 16'h0001;
        end
        if (ext_ev && op == MODE_RELOAD)
            cnt_d = rcap_q;
        if (wr_cnt_lo)
            cnt_d[7:0] = wdata;
        if (wr_cnt_hi)
            cnt_d[15:8] = wdata;
        rcap_d = rcap_q;
        if (wr_rcap_lo)
            rcap_d[7:0] = wdata;
        if (wr_rcap_hi)
            rcap_d[15:8] = wdata;
        // a capture in the same cycle beats a software write
        if (ext_ev && op == MODE_CAPTURE)
            rcap_d = cnt_q;
        // hardware set wins over a software clear
        tf_d = ovf | (wr_ctrl ? wdata[`CTRL_TF] : tf_q);
        base_exf = wr_ctrl ? wdata[`CTRL_EXF] : exf_q;
        exf_d = updown ? (base_exf ^ ovf) : (base_exf | ext_ev);
        ctl_d = wr_ctrl ? wdata[3:0] : ctl_q;
        fd_d = wr_mode ? wdata[`MODE_FD] : fd_q;
        oe_d = wr_mode ? wdata[`MODE_OE] : oe_q;
        dcen_d = wr_mode ? wdata[`MODE_DCEN] : dcen_q;
        co_d = (op == MODE_CLKOUT && ovf) ? ~co_q : co_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_q <= 4'h0;
            tf_q <= 1'b0;
            exf_q <= 1'b0;
            fd_q <= 1'b0;
            oe_q <= 1'b0;
            dcen_q <= 1'b0;
            cnt_q <= 16'h0000;
            rcap_q <= 16'h0000;
            cpin_q <= 1'b1;
            tpin_q <= 1'b1;
            co_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            tf_q <= tf_d;
            exf_q <= exf_d;
            fd_q <= fd_d;
            oe_q <= oe_d;
            dcen_q <= dcen_d;
            cnt_q <= cnt_d;
            rcap_q <= rcap_d;
            cpin_q <= count_pin_i;
            tpin_q <= trig_pin_i;
            co_q <= co_d;
        end
    end

    assign ctrl = {tf_q, exf_q, 2'b00, ctl_q};
    assign mode = {fd_q, 5'b00000, oe_q, dcen_q};
    assign count = cnt_q;
    assign rcap = rcap_q;
    assign irq_req = tf_q | (exf_q & ~updown);
    assign count_pin_o = co_q;
    assign count_pin_oe = oe_q;
endmodule // timer_unit

// [design/banked_timer3_timer4.sv]
`timescale 1ns/1ns
`include "timer34_map.svh"
module banked_timer3_timer4
    import timer34_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic third_timer_count_pin_i,
    output logic third_timer_count_pin_o,
    output logic third_timer_count_pin_oe,
    input wire logic third_timer_trigger_pin,
    input wire logic fourth_timer_count_pin_i,
    output logic fourth_timer_count_pin_o,
    output logic fourth_timer_count_pin_oe,
    input wire logic fourth_timer_trigger_pin,
    output logic third_timer_irq,
    output logic third_timer_irq_high,
    output logic fourth_timer_irq,
    output logic fourth_timer_irq_high
);
    logic [2:0] bank_q, bank_d;
    logic [7:0] ie_q, ie_d, ip_q, ip_d, rdata_q, rdata_d;
    logic [3:0] div_q, div_d;
    logic div12_tick, sel3, sel4;
    logic [5:0] wr3, wr4;
    logic [7:0] ctrl3, ctrl4, mode3, mode4;
    logic [15:0] cnt3, cnt4, rcap3, rcap4;
    logic tick3, req3, req4;
    logic [7:0] sel_ctrl, sel_mode;
    logic [15:0] sel_cnt, sel_rcap;

    // ----------------------------------------
    // system clock divider, shared by both timers
    // ----------------------------------------
    always_comb begin
        div12_tick = (div_q == `DIV_LAST);
        div_d = div12_tick ? 4'h0 : div_q + 4'h1;
    end

    always_ff @(posedge clk) begin
        if (srst)
            div_q <= 4'h0;
        else
            div_q <= div_d;
    end

    // ----------------------------------------
    // banked write decode
    // ----------------------------------------
    always_comb begin
        logic [5:0] hit;
        hit = 6'h00;
        sel3 = (bank_q == `BANK_T3);
        sel4 = (bank_q == `BANK_T4);
        if (sfr_wr) begin
            hit[0] = (sfr_addr == `CTRL_ADDR);
            hit[1] = (sfr_addr == `MODE_ADDR);
            hit[2] = (sfr_addr == `CNT_LO_ADDR);
            hit[3] = (sfr_addr == `CNT_HI_ADDR);
            hit[4] = (sfr_addr == `RCAP_LO_ADDR);
            hit[5] = (sfr_addr == `RCAP_HI_ADDR);
        end
        wr3 = sel3 ? hit : 6'h00;
        wr4 = sel4 ? hit : 6'h00;
    end

    // ----------------------------------------
    // shared registers: bank index, enables, priorities
    // ----------------------------------------
    always_comb begin
        bank_d = bank_q;
        ie_d = ie_q;
        ip_d = ip_q;
        if (sfr_wr && sfr_addr == `BANK_ADDR)
            bank_d = sfr_wdata[2:0];
        // bits 5:4 are reserved and read back as zero
        if (sfr_wr && sfr_addr == `IE2_ADDR)
            ie_d = sfr_wdata & `IE2_RW_MASK;
        if (sfr_wr && sfr_addr == `IP2_ADDR)
            ip_d = sfr_wdata & `IE2_RW_MASK;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bank_q <= 3'h0;
            ie_q <= 8'h00;
            ip_q <= 8'h00;
        end else begin
            bank_q <= bank_d;
            ie_q <= ie_d;
            ip_q <= ip_d;
        end
    end

    // ----------------------------------------
    // the two timers
    // ----------------------------------------
    timer_unit u_t3 (
        .clk(clk),
        .srst(srst),
        .div12_tick(div12_tick),
        .wr_ctrl(wr3[0]),
        .wr_mode(wr3[1]),
        .wr_cnt_lo(wr3[2]),
        .wr_cnt_hi(wr3[3]),
        .wr_rcap_lo(wr3[4]),
        .wr_rcap_hi(wr3[5]),
        .wdata(sfr_wdata),
        .count_pin_i(third_timer_count_pin_i),
        .trig_pin_i(third_timer_trigger_pin),
        .ctrl(ctrl3),
        .mode(mode3),
        .count(cnt3),
        .rcap(rcap3),
        .tick(tick3),
        .irq_req(req3),
        .count_pin_o(third_timer_count_pin_o),
        .count_pin_oe(third_timer_count_pin_oe)
    );

    timer_unit u_t4 (
        .clk(clk),
        .srst(srst),
        .div12_tick(div12_tick),
        .wr_ctrl(wr4[0]),
        .wr_mode(wr4[1]),
        .wr_cnt_lo(wr4[2]),
        .wr_cnt_hi(wr4[3]),
        .wr_rcap_lo(wr4[4]),
        .wr_rcap_hi(wr4[5]),
        .wdata(sfr_wdata),
        .count_pin_i(fourth_timer_count_pin_i),
        .trig_pin_i(fourth_timer_trigger_pin),
        .ctrl(ctrl4),
        .mode(mode4),
        .count(cnt4),
        .rcap(rcap4),
        .tick(),
        .irq_req(req4),
        .count_pin_o(fourth_timer_count_pin_o),
        .count_pin_oe(fourth_timer_count_pin_oe)
    );

    // ----------------------------------------
    // read path, registered; unmapped reads give zero
    // ----------------------------------------
    always_comb begin
        sel_ctrl = sel3 ? ctrl3 : (sel4 ? ctrl4 : 8'h00);
        sel_mode = sel3 ? mode3 : (sel4 ? mode4 : 8'h00);
        sel_cnt = sel3 ? cnt3 : (sel4 ? cnt4 : 16'h0000);
        sel_rcap = sel3 ? rcap3 : (sel4 ? rcap4 : 16'h0000);
        rdata_d = rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                `BANK_ADDR: rdata_d = {5'b00000, bank_q};
                `IE2_ADDR: rdata_d = ie_q;
                `IP2_ADDR: rdata_d = ip_q;
                `CTRL_ADDR: rdata_d = sel_ctrl;
                `MODE_ADDR: rdata_d = sel_mode;
                `CNT_LO_ADDR: rdata_d = sel_cnt[7:0];
                `CNT_HI_ADDR: rdata_d = sel_cnt[15:8];
                `RCAP_LO_ADDR: rdata_d = sel_rcap[7:0];
                `RCAP_HI_ADDR: rdata_d = sel_rcap[15:8];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    assign sfr_rdata = rdata_q;

    // ----------------------------------------
    // interrupt requests to the processor
    // ----------------------------------------
    assign third_timer_irq = ie_q[`IRQ_T3_BIT] & req3;
    assign third_timer_irq_high = ip_q[`IRQ_T3_BIT];
    assign fourth_timer_irq = ie_q[`IRQ_T4_BIT] & req4;
    assign fourth_timer_irq_high = ip_q[`IRQ_T4_BIT];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic cpin3_q, tpin3_q;
    always_ff @(posedge clk) begin
        cpin3_q <= third_timer_count_pin_i;
        tpin3_q <= third_timer_trigger_pin;
    end

    sequence s_bank_ctrl_wr;
        sfr_wr && sfr_addr == `CTRL_ADDR && bank_q == `BANK_T3;
    endsequence

    sequence s_no_cnt_wr;
        !(wr3[2] || wr3[3]);
    endsequence

    chk_bank_route: assert property (
        s_bank_ctrl_wr |=> ctrl3[3:0] == $past(sfr_wdata[3:0])
            && $stable(ctrl4[3:0]))
        else $error("bank write did not reach timer three only");

    chk_ovf_sticky: assert property (
        $fell(ctrl3[`CTRL_TF]) |-> $past(wr3[0])
            && !$past(sfr_wdata[`CTRL_TF]))
        else $error("overflow flag cleared without software zero");

    chk_exf_gate: assert property (
        $rose(ctrl3[`CTRL_EXF]) && !$past(mode3[`MODE_DCEN])
        && !$past(wr3[0])
        |-> $past(ctrl3[`CTRL_EXEN]) && $past(tpin3_q)
            && !$past(third_timer_trigger_pin))
        else $error("event flag set without enabled trigger edge");

    chk_run_stop: assert property (
        (!ctrl3[`CTRL_RUN] && !ctrl3[`CTRL_EXEN]) and s_no_cnt_wr
        |=> $stable(cnt3))
        else $error("count moved while stopped");

    chk_counter_step: assert property (
        (ctrl3[`CTRL_RUN] && ctrl3[`CTRL_CT] && !mode3[`MODE_DCEN]
        && !ctrl3[`CTRL_EXEN] && cpin3_q && !third_timer_count_pin_i
        && cnt3 != `CNT_TOP) and s_no_cnt_wr
        |=> cnt3 == $past(cnt3) + 16'h0001)
        else $error("counter did not step by one on pin edge");

    chk_capture_copy: assert property (
        ctrl3[`CTRL_CPRL] && ctrl3[`CTRL_EXEN] && tpin3_q
        && !third_timer_trigger_pin && !(mode3[`MODE_OE]
        && !ctrl3[`CTRL_CT])
        |=> rcap3 == $past(cnt3))
        else $error("capture did not copy the count");

    chk_up_reload: assert property (
        (tick3 && cnt3 == `CNT_TOP && !ctrl3[`CTRL_CPRL]
        && !ctrl3[`CTRL_EXEN] && !mode3[`MODE_DCEN]) and s_no_cnt_wr
        |=> cnt3 == $past(rcap3) && ctrl3[`CTRL_TF])
        else $error("up overflow did not reload");

    chk_down_reload: assert property (
        (tick3 && mode3[`MODE_DCEN] && !ctrl3[`CTRL_CPRL]
        && !(mode3[`MODE_OE] && !ctrl3[`CTRL_CT])
        && !third_timer_trigger_pin && cnt3 == rcap3) and s_no_cnt_wr
        |=> cnt3 == `CNT_TOP && ctrl3[`CTRL_TF])
        else $error("down overflow did not load ffff");

    chk_irq_gate: assert property (
        third_timer_irq |-> ie_q[`IRQ_T3_BIT]
            && (ctrl3[`CTRL_TF] || ctrl3[`CTRL_EXF]))
        else $error("timer three request without enable or flag");

    chk_updown_noirq: assert property (
        mode3[`MODE_DCEN] && !ctrl3[`CTRL_CPRL] && !ctrl3[`CTRL_TF]
        && !(mode3[`MODE_OE] && !ctrl3[`CTRL_CT])
        |-> !req3)
        else $error("event flag raised request in up/down mode");
endmodule // banked_timer3_timer4

// [tb/timer_pin_model.sv]
`timescale 1ns/1ns
module timer_pin_model (
    input wire logic clk,
    input wire logic count3_o,
    input wire logic count3_oe,
    input wire logic count4_o,
    input wire logic count4_oe,
    output logic count3_i,
    output logic trig3,
    output logic count4_i,
    output logic trig4
);
    // ----------------------------------------
    // pin levels: 0 count3, 1 trig3, 2 count4, 3 trig4
    // ----------------------------------------
    logic [3:0] drv_q = 4'hf;

    // pin is wired to the device whenever it drives it as clock out
    assign count3_i = count3_oe ? count3_o : drv_q[0];
    assign count4_i = count4_oe ? count4_o : drv_q[2];
    assign trig3 = drv_q[1];
    assign trig4 = drv_q[3];

    task automatic set_level(input int sel, input logic v);
        @(posedge clk);
        drv_q[sel] <= v;
    endtask

    // one low cycle then high cycles, so every falling edge is seen
    task automatic pulse(input int sel);
        set_level(sel, 1'b0);
        set_level(sel, 1'b1);
        @(posedge clk);
    endtask
endmodule // timer_pin_model

// [tb/banked_timer3_timer4_tb_top.sv]
`timescale 1ns/1ns
`include "timer34_map.svh"
module banked_timer3_timer4_tb_top;
    logic clk;
    logic srst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    logic c3_i, c3_o, c3_oe, t3, c4_i, c4_o, c4_oe, t4;
    logic irq3, irq3_hi, irq4, irq4_hi;
    logic [7:0] rd_val;
    logic [15:0] v16;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    timer_pin_model pins (.clk(clk), .count3_o(c3_o), .count3_oe(c3_oe),
        .count4_o(c4_o), .count4_oe(c4_oe), .count3_i(c3_i), .trig3(t3),
        .count4_i(c4_i), .trig4(t4));

    banked_timer3_timer4 uut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .third_timer_count_pin_i(c3_i),
        .third_timer_count_pin_o(c3_o), .third_timer_count_pin_oe(c3_oe),
        .third_timer_trigger_pin(t3), .fourth_timer_count_pin_i(c4_i),
        .fourth_timer_count_pin_o(c4_o), .fourth_timer_count_pin_oe(c4_oe),
        .fourth_timer_trigger_pin(t4), .third_timer_irq(irq3),
        .third_timer_irq_high(irq3_hi), .fourth_timer_irq(irq4),
        .fourth_timer_irq_high(irq4_hi));

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic complete_run();
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // data is registered, so it is taken just after the following edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 rd_val = sfr_rdata;
    endtask

    task automatic rd_pair(input logic [7:0] lo);
        rd(lo);
        v16[7:0] = rd_val;
        rd(lo + 8'h01);
        v16[15:8] = rd_val;
    endtask

    task automatic wr_pair(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 8'h01, v[15:8]);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        wr(`BANK_ADDR, 8'h03);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0000);
        rd(`MODE_ADDR);
        chk(rd_val, 16'h0000);
        rd(`IE2_ADDR);
        chk(rd_val, 16'h0000);
        rd(`IP2_ADDR);
        chk(rd_val, 16'h0000);
    endtask

    task automatic t_bank();
        wr_pair(`CNT_LO_ADDR, 16'h0011);
        wr(`BANK_ADDR, 8'h04);
        wr_pair(`CNT_LO_ADDR, 16'h0022);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0022);
        wr(`BANK_ADDR, 8'h05);
        wr(`CTRL_ADDR, 8'h04);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0000);
        wr(`BANK_ADDR, 8'h03);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0011);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0000);
        rd(8'h00);
        chk(rd_val, 16'h0000);
    endtask

    task automatic t_count();
        wr_pair(`CNT_LO_ADDR, 16'h0000);
        wr(`CTRL_ADDR, 8'h06);
        repeat (5) pins.pulse(0);
        pins.pulse(2);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0005);
        wr(`CTRL_ADDR, 8'h02);
        repeat (2) pins.pulse(0);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0005);
    endtask

    task automatic t_reload();
        wr_pair(`RCAP_LO_ADDR, 16'h1234);
        wr_pair(`CNT_LO_ADDR, 16'hfffe);
        wr(`IE2_ADDR, 8'h40);
        wr(`IP2_ADDR, 8'h40);
        wr(`CTRL_ADDR, 8'h06);
        rd(`CTRL_ADDR);
        chk(irq3, 1'b0);
        chk(irq3_hi, 1'b1);
        repeat (2) pins.pulse(0);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h1234);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0086);
        chk(irq3, 1'b1);
        wr(`IE2_ADDR, 8'h00);
        rd(`IE2_ADDR);
        chk(irq3, 1'b0);
        wr(`CTRL_ADDR, 8'h06);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0006);
        wr(`IE2_ADDR, 8'hff);
        rd(`IE2_ADDR);
        chk(rd_val, 16'h00cf);
        wr(`IE2_ADDR, 8'h00);
        wr(`IP2_ADDR, 8'h00);
    endtask

    task automatic t_capture();
        wr(`CTRL_ADDR, 8'h0f);
        wr_pair(`CNT_LO_ADDR, 16'h0abc);
        pins.pulse(1);
        rd_pair(`RCAP_LO_ADDR);
        chk(v16, 16'h0abc);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h004f);
        wr(`CTRL_ADDR, 8'h07);
        wr_pair(`CNT_LO_ADDR, 16'h0bcd);
        pins.pulse(1);
        rd_pair(`RCAP_LO_ADDR);
        chk(v16, 16'h0abc);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0007);
    endtask

    task automatic t_down();
        wr(`CTRL_ADDR, 8'h02);
        wr(`MODE_ADDR, 8'h01);
        pins.set_level(1, 1'b0);
        wr_pair(`RCAP_LO_ADDR, 16'h0005);
        wr_pair(`CNT_LO_ADDR, 16'h0007);
        wr(`CTRL_ADDR, 8'h06);
        pins.pulse(0);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0006);
        wr_pair(`CNT_LO_ADDR, 16'h0005);
        pins.pulse(0);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'hffff);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h00c6);
        pins.set_level(1, 1'b1);
        pins.pulse(0);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0005);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h0086);
        wr(`CTRL_ADDR, 8'h00);
        wr(`MODE_ADDR, 8'h00);
    endtask

    // divider phase is free running, so allow a small window
    task automatic t_timer(input logic [7:0] md, input int n, input int lo,
                           input int hi);
        wr(`MODE_ADDR, md);
        wr_pair(`CNT_LO_ADDR, 16'h0000);
        wr(`CTRL_ADDR, 8'h04);
        repeat (n) @(posedge clk);
        wr(`CTRL_ADDR, 8'h00);
        rd_pair(`CNT_LO_ADDR);
        chk(16'(v16 >= lo && v16 <= hi), 16'h0001);
    endtask

    task automatic t_clkout();
        wr(`MODE_ADDR, 8'h02);
        rd(`MODE_ADDR);
        chk(rd_val, 16'h0002);
        chk(c3_oe, 1'b1);
        chk(c4_oe, 1'b0);
        wr(`MODE_ADDR, 8'h82);
        wr_pair(`RCAP_LO_ADDR, 16'hfffe);
        wr_pair(`CNT_LO_ADDR, 16'hfffe);
        wr(`CTRL_ADDR, 8'h04);
        @(posedge clk);
        wr(`CTRL_ADDR, 8'h00);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'hffff);
        chk(c3_o, 1'b1);
        wr(`MODE_ADDR, 8'h00);
        rd(`MODE_ADDR);
        chk(c3_oe, 1'b0);
    endtask

    task automatic t_four();
        wr(`BANK_ADDR, 8'h04);
        wr(`IE2_ADDR, 8'h80);
        wr(`IP2_ADDR, 8'h80);
        wr_pair(`CNT_LO_ADDR, 16'h0010);
        wr_pair(`RCAP_LO_ADDR, 16'h0100);
        wr(`CTRL_ADDR, 8'h0e);
        pins.pulse(2);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0011);
        chk(irq4, 1'b0);
        pins.pulse(3);
        rd_pair(`CNT_LO_ADDR);
        chk(v16, 16'h0100);
        rd(`CTRL_ADDR);
        chk(rd_val, 16'h004e);
        chk(irq4, 1'b1);
        chk(irq4_hi, 1'b1);
        chk(irq3, 1'b0);
        wr(`IE2_ADDR, 8'h40);
        rd(`IE2_ADDR);
        chk(irq4, 1'b0);
        wr(`CTRL_ADDR, 8'h00);
        wr(`IE2_ADDR, 8'h00);
        wr(`IP2_ADDR, 8'h00);
        wr(`BANK_ADDR, 8'h03);
    endtask

    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_bank();
        t_count();
        t_reload();
        t_capture();
        t_down();
        t_timer(8'h80, 40, 40, 44);
        t_timer(8'h00, 240, 19, 22);
        t_four();
        t_clkout();
        complete_run();
    end
endmodule // banked_timer3_timer4_tb_top
